// >>> testbench/hpcb_bridge_assertions.sv
// Purpose: Port-level checks of the config access bridge
// Assumes: Bound to hpcb_bridge
// Notes: One clock domain
`timescale 1ns/10ps
module hpcb_bridge_assertions (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Reset sequencing
  input wire logic supply_power_good_i,
  input wire logic pci_reset_n_o,
  input wire logic processor_reset_n_o,
  input wire logic agent0_bus_request_n_o,
  // Request side
  input wire hpcb_pkg::hpcb_io_req_type io_req_i,
  input wire logic io_ready_o,
  input wire logic [31:0] io_rdata_o,
  input wire hpcb_pkg::hpcb_cfg_req_type cfg_req_o,
  input wire logic cfg_done_i,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic [31:0] cfg_target_select_o
);
  import hpcb_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_sel_mask;
    (cfg_target_select_o & ~HPCB_SEL_WMASK) == 32'h0;
  endproperty
  a_sel_mask: assert property (p_sel_mask)
    else $error("select reserved bits set");
  property p_sel_write;
    io_ready_o && $past(io_req_i.valid) && $past(io_req_i.write) &&
      $past(io_req_i.addr) == HPCB_SEL_ADDR && $past(io_req_i.be) == 4'hf
      |-> cfg_target_select_o == ($past(io_req_i.wdata) & HPCB_SEL_WMASK);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write not stored");
  property p_idsel;
    cfg_req_o.valid |-> cfg_req_o.idsel ==
      (cfg_req_o.dev[4] ? 32'h0 : 32'h1 << (HPCB_IDSEL_BASE + cfg_req_o.dev));
  endproperty
  a_idsel: assert property (p_idsel)
    else $error("select line wrong");
  property p_seg;
    cfg_req_o.valid |-> cfg_req_o.secondary == (cfg_req_o.bus != HPCB_PRIMARY_BUS);
  endproperty
  a_seg: assert property (p_seg)
    else $error("segment wrong");
  property p_fields;
    $rose(cfg_req_o.valid) |-> {cfg_req_o.bus, cfg_req_o.dev, cfg_req_o.fn,
      cfg_req_o.regno} == cfg_target_select_o[23:2];
  endproperty
  a_fields: assert property (p_fields)
    else $error("config fields wrong");
  property p_launch;
    $rose(cfg_req_o.valid) |-> io_req_i.valid && io_req_i.addr == HPCB_WIN_ADDR &&
      cfg_target_select_o[31] && cfg_req_o.be == io_req_i.be;
  endproperty
  a_launch: assert property (p_launch)
    else $error("config cycle cause wrong");
  property p_cfg_ready;
    cfg_req_o.valid && cfg_done_i |=> io_ready_o &&
      io_rdata_o == ($past(cfg_req_o.write) ? 32'h0 : $past(cfg_rdata_i));
  endproperty
  a_cfg_ready: assert property (p_cfg_ready)
    else $error("config answer wrong");
  property p_pg;
    !supply_power_good_i |=> !pci_reset_n_o && !processor_reset_n_o;
  endproperty
  a_pg: assert property (p_pg)
    else $error("resets not asserted");
  property p_rst_order;
    $rose(processor_reset_n_o) |-> pci_reset_n_o && $past(agent0_bus_request_n_o) == 1'b0;
  endproperty
  a_rst_order: assert property (p_rst_order)
    else $error("request not before reset release");
  c_cfg: cover property ($rose(cfg_req_o.valid));
  c_ready: cover property ($rose(io_ready_o));
  c_boot: cover property ($rose(processor_reset_n_o));
endmodule : hpcb_bridge_assertions

// >>> testbench/hpcb_far_model.sv
// Purpose: Far-side responder for one valid/done handshake
// Assumes: Request valid held until the cycle after done
// Notes: Read data scrambles outside the done cycle
`timescale 1ns/10ps
module hpcb_far_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Request
  input wire logic req_valid_i,
  input wire logic [3:0] wait_i,
  input wire logic [31:0] resp_data_i,
  // Response
  output logic done_o,
  output logic [31:0] rdata_o
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 4'h0;
      done_o <= 1'b0;
      rdata_o <= 32'h0;
    end
    else if (req_valid_i && !done_o && cnt_q == wait_i)
    begin
      cnt_q <= 4'h0;
      done_o <= 1'b1;
      rdata_o <= resp_data_i;
    end
    else
    begin
      cnt_q <= (req_valid_i && !done_o) ? cnt_q + 4'h1 : 4'h0;
      done_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : hpcb_far_model

// >>> testbench/tb_host_pci_config_access_bridge.sv
// Purpose: Self-checking bench for the config access bridge
// Assumes: Far-side responders answer config and forwarded cycles
// Notes: Scenarios run one request at a time
`timescale 1ns/10ps
module tb_host_pci_config_access_bridge;
  import hpcb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pg = 1'b1;
  logic [3:0] wait_c = 4'h0;
  hpcb_io_req_type req = '0;
  hpcb_io_req_type fwd_req, capf;
  hpcb_cfg_req_type cfg_req, cap;
  logic pci_rst_n, cpu_rst_n, a0_n, io_ready, cfg_done, fwd_done, seen_cfg, seen_fwd;
  logic [31:0] io_rdata, cfg_rdata, fwd_rdata, sel;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  hpcb_bridge dut (.core_clk_i(clk), .rst_n_i(rst_n), .supply_power_good_i(pg),
    .pci_reset_n_o(pci_rst_n), .processor_reset_n_o(cpu_rst_n),
    .agent0_bus_request_n_o(a0_n), .io_req_i(req), .io_ready_o(io_ready),
    .io_rdata_o(io_rdata), .cfg_req_o(cfg_req), .cfg_done_i(cfg_done),
    .cfg_rdata_i(cfg_rdata), .fwd_req_o(fwd_req), .fwd_done_i(fwd_done),
    .fwd_rdata_i(fwd_rdata), .cfg_target_select_o(sel));
  hpcb_far_model u_cfg (.core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(cfg_req.valid),
    .wait_i(wait_c), .resp_data_i({16'hc0f9, cfg_req.bus, cfg_req.regno, 2'b11}),
    .done_o(cfg_done), .rdata_o(cfg_rdata));
  hpcb_far_model u_fwd (.core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(fwd_req.valid),
    .wait_i(wait_c), .resp_data_i({fwd_req.addr, 16'h5a5a}),
    .done_o(fwd_done), .rdata_o(fwd_rdata));
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : ck
  task automatic give_verdict;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Waits for each answer before the next request
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
    input logic [31:0] d);
    int n;
    n = 0;
    cap = '0;
    capf = '0;
    seen_cfg = 1'b0;
    seen_fwd = 1'b0;
    @(posedge clk);
    req <= '{1'b1, w, a, be, d};
    do
    begin
      @(posedge clk);
      n++;
      if (cfg_req.valid === 1'b1)
      begin
        seen_cfg = 1'b1;
        cap = cfg_req;
      end
      if (fwd_req.valid === 1'b1)
      begin
        seen_fwd = 1'b1;
        capf = fwd_req;
      end
    end
    while (io_ready !== 1'b1 && n < 50);
    req.valid <= 1'b0;
    if (n >= 50)
      ck("io_ready", 1, 0);
  endtask : io
  task automatic boot;
    int n;
    n = 0;
    while (pci_rst_n !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    ck("pci_hold", 1, n >= HPCB_PCIRST_CYC && n <= HPCB_PCIRST_CYC + 3);
    ck("cpu_rst_n", 0, cpu_rst_n);
    ck("a0_n", 0, a0_n);
    ck("sel_rst", HPCB_SEL_RST, sel);
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    ck("setup", 1, n >= HPCB_REQ_SETUP_CYC && n <= HPCB_REQ_SETUP_CYC + 1);
    ck("a0_rel", 1, a0_n);
  endtask : boot
  task automatic t_sel;
    io(1'b1, HPCB_SEL_ADDR, 4'hf, 32'hffff_ffff);
    ck("sel_all", HPCB_SEL_WMASK, sel);
    io(1'b0, HPCB_SEL_ADDR, 4'hf, 32'h0);
    ck("sel_rd", HPCB_SEL_WMASK, io_rdata);
    io(1'b1, HPCB_SEL_ADDR, 4'h3, 32'h0);
    ck("sel_part", HPCB_SEL_WMASK, sel);
    ck("part_fwd", 1, seen_fwd);
    ck("fwd_part", {1'b1, HPCB_SEL_ADDR, 4'h3}, {capf.write, capf.addr, capf.be});
    io(1'b0, HPCB_SEL_ADDR, 4'h1, 32'h0);
    ck("part_rd", {HPCB_SEL_ADDR, 16'h5a5a}, io_rdata);
  endtask : t_sel
  task automatic t_cfg(input logic [7:0] b, input logic [4:0] d, input logic [3:0] be);
    io(1'b1, HPCB_SEL_ADDR, 4'hf, {8'h80, b, d, 3'h5, 6'h2a, 2'b11});
    io(1'b0, HPCB_WIN_ADDR, be, 32'h0);
    ck("cfg_rd", {16'hc0f9, b, 6'h2a, 2'b11}, io_rdata);
    ck("idsel", d[4] ? 32'h0 : 32'h1 << (16 + d), cap.idsel);
    ck("seg", b != 8'h00, cap.secondary);
    ck("fields", {b, d, 3'h5, 6'h2a}, {cap.bus, cap.dev, cap.fn, cap.regno});
    ck("be", be, cap.be);
    io(1'b1, HPCB_WIN_ADDR, be, 32'h1234_5678);
    ck("cfg_wr", 32'h1234_5678, cap.write ? cap.wdata : 32'h0);
  endtask : t_cfg
  task automatic t_off;
    io(1'b1, HPCB_SEL_ADDR, 4'hf, 32'h0000_0800);
    io(1'b0, HPCB_WIN_ADDR, 4'hf, 32'h0);
    ck("off_cfg", 0, seen_cfg);
    ck("off_fwd", {1'b0, HPCB_WIN_ADDR, 4'hf}, {capf.write, capf.addr, capf.be});
    ck("off_rd", {HPCB_WIN_ADDR, 16'h5a5a}, io_rdata);
  endtask : t_off
  task automatic t_pg;
    pg <= 1'b0;
    repeat (2) @(posedge clk);
    ck("pg_pci", 0, pci_rst_n);
    ck("pg_cpu", 0, cpu_rst_n);
    pg <= 1'b1;
    boot();
  endtask : t_pg
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    boot();
    t_sel();
    t_cfg(8'h00, 5'd0, 4'hf);
    wait_c <= 4'h5;
    t_cfg(8'h00, 5'd15, 4'h3);
    t_cfg(8'h03, 5'd16, 4'hc);
    wait_c <= 4'h0;
    t_cfg(8'h01, 5'd31, 4'h0);
    t_off();
    t_pg();
    give_verdict();
  end
endmodule : tb_host_pci_config_access_bridge
bind hpcb_bridge hpcb_bridge_assertions u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .supply_power_good_i(supply_power_good_i), .pci_reset_n_o(pci_reset_n_o),
  .processor_reset_n_o(processor_reset_n_o), .agent0_bus_request_n_o(agent0_bus_request_n_o),
  .io_req_i(io_req_i), .io_ready_o(io_ready_o), .io_rdata_o(io_rdata_o),
  .cfg_req_o(cfg_req_o), .cfg_done_i(cfg_done_i), .cfg_rdata_i(cfg_rdata_i),
  .cfg_target_select_o(cfg_target_select_o));

// >>> verilog/hpcb_bridge.sv
// Purpose: Host I/O to PCI configuration access bridge, mechanism #1
// Assumes: One processor I/O request at a time, held until io_ready_o
// Notes: Non-configuration I/O is forwarded unchanged on the fwd port
`timescale 1ns/10ps

module hpcb_bridge (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Supply and reset outputs
  input wire logic supply_power_good_i,
  output logic pci_reset_n_o,
  output logic processor_reset_n_o,
  output logic agent0_bus_request_n_o,
  // Processor I/O request
  input wire hpcb_pkg::hpcb_io_req_type io_req_i,
  output logic io_ready_o,
  output logic [31:0] io_rdata_o,
  // Configuration cycle port
  output hpcb_pkg::hpcb_cfg_req_type cfg_req_o,
  input wire logic cfg_done_i,
  input wire logic [31:0] cfg_rdata_i,
  // Forwarded ordinary I/O
  output hpcb_pkg::hpcb_io_req_type fwd_req_o,
  input wire logic fwd_done_i,
  input wire logic [31:0] fwd_rdata_i,
  // Status
  output logic [31:0] cfg_target_select_o
);
  import hpcb_pkg::*;

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  logic pci_n, cpu_n, req_n, regs_init;

  hpcb_reset_seq u_reset_seq (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .supply_power_good_i(supply_power_good_i),
    .pci_reset_n_o(pci_n),
    .processor_reset_n_o(cpu_n),
    .agent0_bus_request_n_o(req_n),
    .regs_init_o(regs_init)
  );

  assign pci_reset_n_o = pci_n;
  assign processor_reset_n_o = cpu_n;
  assign agent0_bus_request_n_o = req_n;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic is_full_dword(input logic [3:0] be);
    is_full_dword = (be == 4'hf);
  endfunction : is_full_dword

  logic [31:0] sel_q, sel_d;
  logic sel_hit, win_hit, sel_cfg, win_cfg;

  always_comb
  begin
    sel_hit = io_req_i.valid && (io_req_i.addr == HPCB_SEL_ADDR);
    win_hit = io_req_i.valid && (io_req_i.addr == HPCB_WIN_ADDR);
    sel_cfg = sel_hit && is_full_dword(io_req_i.be);
    win_cfg = win_hit && sel_q[HPCB_EN_BIT];
  end

  // ----------------------------------------
  // Selection decode
  // ----------------------------------------
  logic [7:0] bus_num;
  logic [4:0] dev_num;
  logic [2:0] fn_num;
  logic [5:0] reg_num;
  logic secondary, idsel_hit;
  logic [31:0] idsel;

  always_comb
  begin
    bus_num = sel_q[HPCB_BUS_LSB +: 8];
    dev_num = sel_q[HPCB_DEV_LSB +: 5];
    fn_num = sel_q[HPCB_FN_LSB +: 3];
    reg_num = sel_q[HPCB_REG_LSB +: 6];
  end

  hpcb_idsel_decode u_idsel (
    .bus_i(bus_num),
    .dev_i(dev_num),
    .secondary_o(secondary),
    .hit_o(idsel_hit),
    .idsel_o(idsel)
  );

  // ----------------------------------------
  // Transfer control
  // ----------------------------------------
  hpcb_state_type state_q, state_d;
  hpcb_cfg_req_type cfg_q, cfg_d;
  hpcb_io_req_type fwd_q, fwd_d;
  logic ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    cfg_d = cfg_q;
    fwd_d = fwd_q;
    ready_d = 1'b0;
    rdata_d = rdata_q;
    unique case (state_q)
      HPCB_IDLE:
      begin
        if (sel_cfg)
        begin
          if (io_req_i.write)
          begin
            sel_d = io_req_i.wdata & HPCB_SEL_WMASK;
          end
          rdata_d = sel_q;
          ready_d = 1'b1;
          state_d = HPCB_DONE;
        end
        else if (win_cfg)
        begin
          cfg_d.valid = 1'b1;
          cfg_d.write = io_req_i.write;
          cfg_d.secondary = secondary;
          cfg_d.bus = bus_num;
          cfg_d.dev = dev_num;
          cfg_d.fn = fn_num;
          cfg_d.regno = reg_num;
          cfg_d.be = io_req_i.be;
          cfg_d.wdata = io_req_i.wdata;
          cfg_d.idsel = idsel_hit ? idsel : 32'h0000_0000;
          state_d = HPCB_CFG;
        end
        else if (io_req_i.valid)
        begin
          fwd_d = io_req_i;
          state_d = HPCB_FWD;
        end
      end
      HPCB_CFG:
      begin
        if (cfg_done_i)
        begin
          cfg_d.valid = 1'b0;
          rdata_d = cfg_q.write ? 32'h0000_0000 : cfg_rdata_i;
          ready_d = 1'b1;
          state_d = HPCB_DONE;
        end
      end
      HPCB_FWD:
      begin
        if (fwd_done_i)
        begin
          fwd_d.valid = 1'b0;
          rdata_d = fwd_q.write ? 32'h0000_0000 : fwd_rdata_i;
          ready_d = 1'b1;
          state_d = HPCB_DONE;
        end
      end
      HPCB_DONE:
      begin
        // One idle cycle lets the requester drop valid
        state_d = HPCB_IDLE;
      end
    endcase
    if (regs_init)
    begin
      state_d = HPCB_IDLE;
      sel_d = HPCB_SEL_RST;
      cfg_d = '0;
      fwd_d = '0;
      ready_d = 1'b0;
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= HPCB_IDLE;
      sel_q <= HPCB_SEL_RST;
      cfg_q <= '0;
      fwd_q <= '0;
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      cfg_q <= cfg_d;
      fwd_q <= fwd_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
    end
  end

  assign io_ready_o = ready_q;
  assign io_rdata_o = rdata_q;
  assign cfg_req_o = cfg_q;
  assign fwd_req_o = fwd_q;
  assign cfg_target_select_o = sel_q;

endmodule : hpcb_bridge

// >>> verilog/hpcb_idsel_decode.sv
// Purpose: Maps bus and device numbers to segment and one-hot select line
// Assumes: Bus 0 is the primary segment, any other bus the secondary one
// Notes: Purely combinational
`timescale 1ns/10ps
module hpcb_idsel_decode (
  // Selection
  input wire logic [7:0] bus_i,
  input wire logic [4:0] dev_i,
  // Result
  output logic secondary_o,
  output logic hit_o,
  output logic [31:0] idsel_o
);
  import hpcb_pkg::*;

  logic [5:0] line;

  always_comb
  begin
    line = 6'(HPCB_IDSEL_BASE) + {1'b0, dev_i};
    secondary_o = (bus_i != HPCB_PRIMARY_BUS);
    idsel_o = 32'h0000_0000;
    hit_o = 1'b0;
    // Only lines 16..31 exist; both segments reach those
    if (line < 6'd32)
    begin
      hit_o = 1'b1;
      idsel_o[line[4:0]] = 1'b1;
    end
  end

endmodule : hpcb_idsel_decode

// >>> verilog/hpcb_pkg.sv
// Purpose: Shared constants and carrier types for the host config access bridge
// Assumes: Single 200 MHz clock domain, synchronous active-low reset
// Notes: Carrier structs group processor I/O requests and config cycle requests
package hpcb_pkg;

  // ----------------------------------------
  // I/O map
  // ----------------------------------------
  localparam logic [15:0] HPCB_SEL_ADDR = 16'h0cf8;
  localparam logic [15:0] HPCB_WIN_ADDR = 16'h0cfc;

  // ----------------------------------------
  // Target-select field layout
  // ----------------------------------------
  localparam int HPCB_EN_BIT = 31;
  localparam int HPCB_BUS_LSB = 16;
  localparam int HPCB_DEV_LSB = 11;
  localparam int HPCB_FN_LSB = 8;
  localparam int HPCB_REG_LSB = 2;
  localparam logic [31:0] HPCB_SEL_WMASK = 32'h80ff_fffc;
  localparam logic [31:0] HPCB_SEL_RST = 32'h0000_0000;
  localparam logic [7:0] HPCB_PRIMARY_BUS = 8'h00;
  localparam int HPCB_IDSEL_BASE = 16;
  localparam int HPCB_PRI_IDSEL_LO = 11;
  localparam int HPCB_SEC_IDSEL_LO = 16;

  // ----------------------------------------
  // Reset sequencing counts
  // ----------------------------------------
  localparam int HPCB_PCIRST_NS = 1000;
  localparam int HPCB_PCIRST_CYC = (HPCB_PCIRST_NS + 4) / 5;
  localparam int HPCB_REQ_SETUP_NS = 100;
  localparam int HPCB_REQ_SETUP_CYC = (HPCB_REQ_SETUP_NS + 4) / 5;
  localparam int HPCB_CNT_W = 10;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } hpcb_io_req_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic secondary;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [5:0] regno;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] idsel;
  } hpcb_cfg_req_type;

  typedef enum logic [3:0] {
    HPCB_IDLE = 4'b0001,
    HPCB_CFG = 4'b0010,
    HPCB_FWD = 4'b0100,
    HPCB_DONE = 4'b1000
  } hpcb_state_type;

  typedef enum logic [3:0] {
    HPCB_R_WAIT = 4'b0001,
    HPCB_R_PCI = 4'b0010,
    HPCB_R_REQ = 4'b0100,
    HPCB_R_RUN = 4'b1000
  } hpcb_rst_state_type;

endpackage : hpcb_pkg

// >>> verilog/hpcb_reset_seq.sv
// Purpose: Power-up reset sequencing for PCI, processors and agent request
// Assumes: supply_power_good_i synchronous to the clock
// Notes: Loss of power good restarts the whole sequence
`timescale 1ns/10ps
module hpcb_reset_seq (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Supply
  input wire logic supply_power_good_i,
  // Outputs
  output logic pci_reset_n_o,
  output logic processor_reset_n_o,
  output logic agent0_bus_request_n_o,
  output logic regs_init_o
);
  import hpcb_pkg::*;

  hpcb_rst_state_type state_q, state_d;
  logic [HPCB_CNT_W-1:0] cnt_q, cnt_d;
  logic pci_n_q, pci_n_d, cpu_n_q, cpu_n_d, req_n_q, req_n_d, init_q, init_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pci_n_d = pci_n_q;
    cpu_n_d = cpu_n_q;
    req_n_d = req_n_q;
    init_d = 1'b0;
    if (!supply_power_good_i)
    begin
      state_d = HPCB_R_WAIT;
      cnt_d = '0;
      pci_n_d = 1'b0;
      cpu_n_d = 1'b0;
      req_n_d = 1'b1;
      init_d = 1'b1;
    end
    else
    begin
      unique case (state_q)
        HPCB_R_WAIT:
        begin
          state_d = HPCB_R_PCI;
          cnt_d = '0;
          init_d = 1'b1;
        end
        HPCB_R_PCI:
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == HPCB_CNT_W'(HPCB_PCIRST_CYC - 1))
          begin
            state_d = HPCB_R_REQ;
            cnt_d = '0;
            pci_n_d = 1'b1;
            req_n_d = 1'b0;
          end
        end
        HPCB_R_REQ:
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == HPCB_CNT_W'(HPCB_REQ_SETUP_CYC - 1))
          begin
            state_d = HPCB_R_RUN;
            cpu_n_d = 1'b1;
            req_n_d = 1'b1;
          end
        end
        HPCB_R_RUN:
        begin
          state_d = HPCB_R_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= HPCB_R_WAIT;
      cnt_q <= '0;
      pci_n_q <= 1'b0;
      cpu_n_q <= 1'b0;
      req_n_q <= 1'b1;
      init_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pci_n_q <= pci_n_d;
      cpu_n_q <= cpu_n_d;
      req_n_q <= req_n_d;
      init_q <= init_d;
    end
  end

  assign pci_reset_n_o = pci_n_q;
  assign processor_reset_n_o = cpu_n_q;
  assign agent0_bus_request_n_o = req_n_q;
  assign regs_init_o = init_q;

endmodule : hpcb_reset_seq
